// file: rtl/gsc_pkg.sv
package gsc_pkg;
	// timing figures in their own units, counts derived from them
	localparam int SYS_CLK_HZ       = 20000000;
	localparam int FAST_RATE_HZ     = 8000;
	localparam int INT_TICK_CYC     = SYS_CLK_HZ / FAST_RATE_HZ;
	localparam int SLOW_PRESCALE    = 8;
	localparam int PLL_SETTLE_US    = 1000;
	localparam int PLL_SETTLE_CYC   = PLL_SETTLE_US * (SYS_CLK_HZ / 1000000);
	localparam int INT_PULSE_US     = 50;
	localparam int INT_PULSE_CYC    = INT_PULSE_US * (SYS_CLK_HZ / 1000000);
	localparam int EXT19M_HZ        = 19200000;
	localparam int EXT32K_HZ        = 32768;
	localparam int EXT32K_FAST_HZ   = 8192;
	localparam int REF19M_DIV       = EXT19M_HZ / FAST_RATE_HZ;
	localparam int REF32K_DIV       = EXT32K_HZ / EXT32K_FAST_HZ;

	// bus address: fixed upper bits, low bit from the pin
	localparam logic [5:0] DEV_ADDR_HI = 6'h34;

	// clock source codes
	localparam logic [2:0] SRC_INTERNAL = 3'h0;
	localparam logic [2:0] SRC_GYRO_X   = 3'h1;
	localparam logic [2:0] SRC_GYRO_Z   = 3'h3;
	localparam logic [2:0] SRC_EXT32K   = 3'h4;
	localparam logic [2:0] SRC_EXT19M   = 3'h5;

	// readable map seen over the serial interface
	localparam logic [7:0] RA_DEV_ADDR  = 8'h00;
	localparam logic [7:0] RA_STATUS    = 8'h01;
	localparam logic [7:0] RA_DATA_FIRST = 8'h02;
	localparam logic [7:0] RA_DATA_LAST = 8'h09;

	// status field positions
	localparam int ST_DATA_POS = 0;
	localparam int ST_LOCK_POS = 2;

	typedef struct packed {
		logic active_low;     // interrupt level inverted in push-pull; open drain ignores it
		logic open_drain;     // pin only pulls, never drives high
		logic latch_en;       // hold until cleared, else fixed pulse
		logic clear_any_read; // any register read clears, else status read
		logic lock_en;        // lock event may interrupt
		logic data_en;        // new data event may interrupt
	} gsc_int_cfg_t;

	typedef struct packed {
		logic [15:0] temp;
		logic [15:0] gyro_x;
		logic [15:0] gyro_y;
		logic [15:0] gyro_z;
	} gsc_sample_t;

	typedef struct packed {
		logic lock;
		logic data;
	} gsc_status_t;
endpackage : gsc_pkg

// file: rtl/gsc_core.sv
`timescale 1ns/1ps
module gsc_core #(
	parameter int SETTLE_CYC = gsc_pkg::PLL_SETTLE_CYC
) (
	input  wire logic                  sys_clk,
	input  wire logic                  nrst,
	input  wire logic                  external_reference_clock_input,
	input  wire logic                  address_select_pin,
	input  wire logic                  scl_in,
	input  wire logic                  sda_in,
	output logic                       sda_out,
	output logic                       sda_oe,
	output logic                       int_out,
	output logic                       int_oe,
	input  wire logic [2:0]            clk_source_sel,
	input  wire logic                  clk_source_load,
	input  wire logic                  slow_rate,
	input  wire logic [7:0]            sample_div,
	input  wire gsc_pkg::gsc_int_cfg_t int_cfg,
	input  wire gsc_pkg::gsc_sample_t  adc_sample,
	output logic [2:0]                 active_clk_source,
	output logic                       clk_locked,
	output gsc_pkg::gsc_status_t       int_status,
	output gsc_pkg::gsc_sample_t       sample_data
);
	import gsc_pkg::*;

	typedef enum logic [2:0] {
		GSC_IDLE, GSC_ADDR, GSC_ACK_ADDR, GSC_WR, GSC_ACK_WR, GSC_RD, GSC_MACK
	} gsc_bus_state_t;

	// read mux for the serial register map
	function automatic logic [7:0] gsc_rd_byte(input logic [7:0] idx, input logic [6:0] dev,
		input gsc_status_t st, input gsc_sample_t s);
		logic [63:0] w;
		logic [7:0]  r;
		w = s;
		r = 8'h00;
		if (idx == RA_DEV_ADDR)
			r = {1'b0, dev};
		else if (idx == RA_STATUS)
			r = 8'(({7'h00, st.lock} << ST_LOCK_POS) | ({7'h00, st.data} << ST_DATA_POS));
		else if (idx >= RA_DATA_FIRST && idx <= RA_DATA_LAST)
			r = w[8 * (int'(RA_DATA_LAST) - int'(idx)) +: 8]; // temperature first, high byte first
		return r;
	endfunction : gsc_rd_byte

	// ---------------- reference clock domain ----------------
	logic        ref_rst_meta_ff, ref_rst_n_ff;
	logic        ref_19m_meta_ff, ref_19m_ff;
	logic [11:0] ref_cnt_ff;
	logic        ref_tick_tgl_ff;
	logic        src_19m_ff;

	// reset and source choice brought across into the reference domain
	always_ff @(posedge external_reference_clock_input) begin
		ref_rst_meta_ff <= nrst;
		ref_rst_n_ff    <= ref_rst_meta_ff;
		ref_19m_meta_ff <= src_19m_ff;
		ref_19m_ff      <= ref_19m_meta_ff;
	end

	// divide the reference to the fast base rate, tick sent as a toggle
	always_ff @(posedge external_reference_clock_input) begin
		if (!ref_rst_n_ff) begin
			ref_cnt_ff      <= 12'h000;
			ref_tick_tgl_ff <= 1'b0;
		end else if (ref_cnt_ff >= (ref_19m_ff ? 12'(REF19M_DIV - 1) : 12'(REF32K_DIV - 1))) begin
			ref_cnt_ff      <= 12'h000;
			ref_tick_tgl_ff <= ~ref_tick_tgl_ff;
		end else begin
			ref_cnt_ff <= ref_cnt_ff + 12'h001;
		end
	end

	// ---------------- system clock domain ----------------
	logic       tick_meta_ff, tick_sync_ff, tick_prev_ff;
	logic       scl_meta_ff, scl_ff, scl_prev_ff;
	logic       sda_meta_ff, sda_ff, sda_prev_ff;
	logic       adsel_meta_ff, adsel_ff;

	// two-flop synchronisers; the first stage feeds no logic, the prev flops give edges
	always_ff @(posedge sys_clk) begin
		tick_meta_ff  <= ref_tick_tgl_ff;
		tick_sync_ff  <= tick_meta_ff;
		tick_prev_ff  <= tick_sync_ff;
		scl_meta_ff   <= scl_in;
		scl_ff        <= scl_meta_ff;
		scl_prev_ff   <= scl_ff;
		sda_meta_ff   <= sda_in;
		sda_ff        <= sda_meta_ff;
		sda_prev_ff   <= sda_ff;
		adsel_meta_ff <= address_select_pin;
		adsel_ff      <= adsel_meta_ff;
	end

	logic [6:0] dev_addr;
	assign dev_addr = {DEV_ADDR_HI, adsel_ff}; // fixed high bits, pin low bit

	// clock source switching and settling
	logic [2:0]  req_src_ff;
	logic [2:0]  active_src_ff;
	logic        locked_ff;
	logic [15:0] settle_cnt_ff;
	logic        lock_evt;

	assign lock_evt = !locked_ff && (settle_cnt_ff == 16'(SETTLE_CYC - 1));

	// starts on the internal clock; moves only when software loads a source
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			req_src_ff    <= SRC_INTERNAL;
			active_src_ff <= SRC_INTERNAL;
			locked_ff     <= 1'b1;
			settle_cnt_ff <= 16'h0000;
			src_19m_ff    <= 1'b0;
		end else if (clk_source_load && clk_source_sel <= SRC_EXT19M) begin
			req_src_ff    <= clk_source_sel; // codes 6 and 7 are refused
			locked_ff     <= 1'b0;
			settle_cnt_ff <= 16'h0000;
			src_19m_ff    <= (clk_source_sel == SRC_EXT19M);
		end else if (lock_evt) begin
			locked_ff     <= 1'b1; // lock declared after the settle time
			active_src_ff <= req_src_ff;
		end else if (!locked_ff) begin
			settle_cnt_ff <= settle_cnt_ff + 16'h0001;
		end
	end

	// fast base tick: internal divider, or reference ticks once an external source is live
	logic [11:0] int_cnt_ff;
	logic        int_tick;
	logic        base_tick;

	always_ff @(posedge sys_clk) begin
		if (!nrst || int_tick)
			int_cnt_ff <= 12'h000;
		else
			int_cnt_ff <= int_cnt_ff + 12'h001;
	end

	assign int_tick  = (int_cnt_ff == 12'(INT_TICK_CYC - 1));
	assign base_tick = (active_src_ff >= SRC_EXT32K) ? (tick_sync_ff ^ tick_prev_ff) : int_tick;

	// slow prescale then programmable divide: 8000 down to 1000/256 samples per second
	logic [2:0] pre_cnt_ff;
	logic [7:0] div_cnt_ff;
	logic       pre_tick;
	logic       sample_evt;

	assign pre_tick   = base_tick && (!slow_rate || pre_cnt_ff == 3'(SLOW_PRESCALE - 1));
	assign sample_evt = pre_tick && (div_cnt_ff >= sample_div);

	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			pre_cnt_ff <= 3'h0;
			div_cnt_ff <= 8'h00;
		end else begin
			if (base_tick)
				pre_cnt_ff <= (slow_rate && !pre_tick) ? pre_cnt_ff + 3'h1 : 3'h0;
			if (pre_tick)
				div_cnt_ff <= sample_evt ? 8'h00 : div_cnt_ff + 8'h01;
		end
	end

	// sample capture; full scale is fixed upstream, no range field exists
	gsc_sample_t data_ff;

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			data_ff <= '0;
		else if (sample_evt)
			data_ff <= adc_sample; // latest three axes and temperature
	end

	// serial slave: samples on rising clock, drives data after falling clock
	gsc_bus_state_t bus_st_ff;
	logic [3:0]     bit_cnt_ff;
	logic [7:0]     shift_ff;
	logic [7:0]     ptr_ff;
	logic           first_wr_ff;
	logic           rw_ff;
	logic           sda_oe_ff;
	logic           mack_ff;
	logic           rd_fetch;
	logic [7:0]     fetch_idx;
	logic [7:0]     rd_byte;
	logic           scl_rise, scl_fall, bus_start, bus_stop;

	assign scl_rise  = scl_ff && !scl_prev_ff;
	assign scl_fall  = !scl_ff && scl_prev_ff;
	assign bus_start = scl_ff && scl_prev_ff && !sda_ff && sda_prev_ff;
	assign bus_stop  = scl_ff && scl_prev_ff && sda_ff && !sda_prev_ff;
	assign rd_fetch  = scl_fall && ((bus_st_ff == GSC_ACK_ADDR && rw_ff) ||
	                               (bus_st_ff == GSC_MACK && mack_ff));
	assign fetch_idx = (bus_st_ff == GSC_MACK) ? ptr_ff + 8'h01 : ptr_ff;
	assign rd_byte   = gsc_rd_byte(fetch_idx, dev_addr, int_status, data_ff);

	// never drives the clock line and only answers its own address
	always_ff @(posedge sys_clk) begin
		if (!nrst || bus_stop) begin
			bus_st_ff  <= GSC_IDLE;
			sda_oe_ff  <= 1'b0;
			bit_cnt_ff <= 4'h0;
		end else if (bus_start) begin
			bus_st_ff  <= GSC_ADDR; // repeated start keeps the pointer
			sda_oe_ff  <= 1'b0;
			bit_cnt_ff <= 4'h0;
		end else begin
			unique case (bus_st_ff)
				GSC_IDLE: begin
					sda_oe_ff <= 1'b0;
				end
				GSC_ADDR, GSC_WR: begin
					if (scl_rise) begin
						shift_ff   <= {shift_ff[6:0], sda_ff};
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (scl_fall && bit_cnt_ff == 4'h8) begin
						bit_cnt_ff <= 4'h0;
						if (bus_st_ff == GSC_ADDR) begin
							if (shift_ff[7:1] == dev_addr) begin
								rw_ff       <= shift_ff[0];
								first_wr_ff <= 1'b1;
								sda_oe_ff   <= 1'b1;
								bus_st_ff   <= GSC_ACK_ADDR;
							end else begin
								bus_st_ff <= GSC_IDLE;
							end
						end else begin
							// first byte is the pointer, later bytes ignored but counted
							ptr_ff      <= first_wr_ff ? shift_ff : ptr_ff + 8'h01;
							first_wr_ff <= 1'b0;
							sda_oe_ff   <= 1'b1;
							bus_st_ff   <= GSC_ACK_WR;
						end
					end
				end
				GSC_ACK_ADDR, GSC_ACK_WR, GSC_MACK: begin
					if (scl_rise && bus_st_ff == GSC_MACK)
						mack_ff <= !sda_ff;
					if (scl_fall) begin
						if (rd_fetch) begin
							shift_ff   <= rd_byte;
							sda_oe_ff  <= !rd_byte[7]; // pull for a leading zero
							ptr_ff     <= fetch_idx; // advance on master ack
							bit_cnt_ff <= 4'h0;
							bus_st_ff  <= GSC_RD;
						end else begin
							sda_oe_ff <= 1'b0;
							bus_st_ff <= (bus_st_ff == GSC_MACK) ? GSC_IDLE : GSC_WR;
						end
					end
				end
				GSC_RD: begin
					if (scl_rise) begin
						bit_cnt_ff <= bit_cnt_ff + 4'h1;
					end else if (scl_fall) begin
						if (bit_cnt_ff == 4'h8) begin
							sda_oe_ff <= 1'b0;
							mack_ff   <= 1'b0;
							bus_st_ff <= GSC_MACK;
						end else begin
							shift_ff  <= {shift_ff[6:0], 1'b0};
							sda_oe_ff <= !shift_ff[6]; // open drain: pull for a zero
						end
					end
				end
				default: begin
					bus_st_ff <= GSC_IDLE;
				end
			endcase
		end
	end

	// status clears requested by reads; status read or any read per config
	logic clr_req;
	assign clr_req = rd_fetch && (int_cfg.clear_any_read || fetch_idx == RA_STATUS);

	// sticky causes; an event in the clearing cycle survives
	gsc_status_t st_ff;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff.lock <= lock_evt || (st_ff.lock && !clr_req);
			st_ff.data <= sample_evt || (st_ff.data && !clr_req);
		end
	end

	// interrupt level: latched until clear, or a fixed pulse per enabled event
	logic [9:0] pulse_cnt_ff;
	logic       new_irq;
	logic       pend;
	logic       irq_lvl;

	assign new_irq = (lock_evt && int_cfg.lock_en) || (sample_evt && int_cfg.data_en);
	assign pend    = (st_ff.lock && int_cfg.lock_en) || (st_ff.data && int_cfg.data_en);
	assign irq_lvl = int_cfg.latch_en ? pend : (pulse_cnt_ff != 10'h000);

	always_ff @(posedge sys_clk) begin
		if (!nrst)
			pulse_cnt_ff <= 10'h000;
		else if (new_irq)
			pulse_cnt_ff <= 10'(INT_PULSE_CYC);
		else if (pulse_cnt_ff != 10'h000)
			pulse_cnt_ff <= pulse_cnt_ff - 10'h001;
	end

	// pin drive: push-pull drives both levels, open drain only pulls low
	logic int_out_ff, int_oe_ff;
	always_ff @(posedge sys_clk) begin
		if (!nrst) begin
			int_out_ff <= 1'b0;
			int_oe_ff  <= 1'b0;
		end else if (int_cfg.open_drain) begin
			int_out_ff <= 1'b0;
			int_oe_ff  <= irq_lvl;
		end else begin
			int_out_ff <= irq_lvl ^ int_cfg.active_low;
			int_oe_ff  <= 1'b1;
		end
	end

	// data line is never driven high; the constant flop keeps the output registered
	logic sda_out_ff;
	always_ff @(posedge sys_clk) begin
		sda_out_ff <= 1'b0;
	end

	assign sda_out           = sda_out_ff;
	assign sda_oe            = sda_oe_ff;
	assign int_out           = int_out_ff;
	assign int_oe            = int_oe_ff;
	assign active_clk_source = active_src_ff;
	assign clk_locked        = locked_ff;
	assign int_status        = st_ff;
	assign sample_data       = data_ff;
endmodule : gsc_core

// file: verification/gsc_core_sva.sv
`timescale 1ns/1ps
module gsc_core_sva #(
	parameter int SETTLE_CYC = 20
) (
	input wire logic                  sys_clk,
	input wire logic                  nrst,
	input wire logic                  scl_in,
	input wire logic                  sda_oe,
	input wire logic                  int_out,
	input wire logic [2:0]            clk_source_sel,
	input wire logic                  clk_source_load,
	input wire gsc_pkg::gsc_int_cfg_t int_cfg,
	input wire logic [2:0]            active_clk_source,
	input wire logic                  clk_locked,
	input wire gsc_pkg::gsc_status_t  int_status,
	input wire gsc_pkg::gsc_sample_t  sample_data
);
	import gsc_pkg::*;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!nrst);
	logic        take;
	logic [31:0] wait_ff;
	assign take = clk_source_load && (clk_source_sel <= 3'h5);
	// unlocked cycles since the last accepted load, held once locked; restarts so a reload is timed afresh
	always_ff @(posedge sys_clk) begin
		if (!nrst) wait_ff <= 32'h0;
		else if (take) wait_ff <= 32'h1;
		else if (!clk_locked) wait_ff <= wait_ff + 32'h1;
	end
	property p_lock_drop; take |=> !clk_locked; endproperty
	a_lock_drop: assert property (p_lock_drop) else $error("lock kept after load");
	property p_lock_time; $rose(clk_locked) |-> wait_ff == SETTLE_CYC + 1; endproperty
	a_lock_time: assert property (p_lock_time) else $error("settle time wrong");
	property p_src_move; $changed(active_clk_source) |-> $rose(clk_locked); endproperty
	a_src_move: assert property (p_src_move) else $error("source moved unlocked");
	property p_lock_flag; $rose(clk_locked) |-> int_status.lock; endproperty
	a_lock_flag: assert property (p_lock_flag) else $error("no lock event");
	property p_refuse;
		clk_source_load && clk_source_sel > 3'h5 && clk_locked |=>
			clk_locked && $stable(active_clk_source);
	endproperty
	a_refuse: assert property (p_refuse) else $error("bad source taken");
	property p_data_flag; $changed(sample_data) |-> int_status.data; endproperty
	a_data_flag: assert property (p_data_flag) else $error("no data event");
	property p_no_init; $changed(sda_oe) |-> !scl_in; endproperty
	a_no_init: assert property (p_no_init) else $error("sda moved with scl high");
	property p_od; $stable(int_cfg) && int_cfg.open_drain |-> !int_out; endproperty
	a_od: assert property (p_od) else $error("open drain drove high");
	property p_pp_level;
		$stable(int_cfg) && int_cfg.latch_en && !int_cfg.open_drain && int_cfg.data_en &&
			int_status.data && $past(int_status.data) |-> int_out != int_cfg.active_low;
	endproperty
	a_pp_level: assert property (p_pp_level) else $error("latched level missing");
	c_lock: cover property ($rose(clk_locked));
	c_data: cover property ($changed(sample_data));
	c_ack: cover property ($rose(sda_oe));
endmodule : gsc_core_sva

bind gsc_core gsc_core_sva #(.SETTLE_CYC(SETTLE_CYC)) u_sva (.sys_clk(sys_clk), .nrst(nrst),
	.scl_in(scl_in), .sda_oe(sda_oe), .int_out(int_out), .clk_source_sel(clk_source_sel),
	.clk_source_load(clk_source_load), .int_cfg(int_cfg),
	.active_clk_source(active_clk_source), .clk_locked(clk_locked),
	.int_status(int_status), .sample_data(sample_data));

// file: verification/gsc_i2c_master.sv
`timescale 1ns/1ps
module gsc_i2c_master (
	input wire logic sys_clk,
	input wire logic sda,
	output logic     scl,
	output logic     sda_low
);
	localparam int Q = 15; // quarter bit, keeps the bus near 333 kHz
	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end
	// four quarters of {scl, sda_low}; sda sampled in mid high phase
	task automatic quad(input logic [7:0] pat, output logic r);
		for (int q = 0; q < 4; q++) begin
			scl = pat[7 - 2 * q];
			sda_low = pat[6 - 2 * q];
			repeat (Q) @(negedge sys_clk);
			if (q == 1) r = sda;
		end
	endtask : quad
	// eight bits msb first, then the ninth; data only moves with scl low
	task automatic xfer(input logic [7:0] tx, input logic nine, output logic [7:0] rx,
		output logic r9);
		for (int i = 7; i >= 0; i--) begin
			quad({1'b0, !tx[i], 1'b1, !tx[i], 1'b1, !tx[i], 1'b0, !tx[i]}, rx[i]);
		end
		quad({1'b0, !nine, 1'b1, !nine, 1'b1, !nine, 1'b0, !nine}, r9);
	endtask : xfer
endmodule : gsc_i2c_master

// file: verification/gsc_core_tb.sv
`timescale 1ns/1ps
module gsc_core_tb;
	import gsc_pkg::*;
	localparam int SETTLE = 20;
	localparam logic [7:0] B_START = 8'h2D;
	localparam logic [7:0] B_STOP = 8'h7A;
	logic         sys_clk = 1'b0;
	logic         nrst = 1'b0;
	logic         ref_clk = 1'b0;
	logic         address_select_pin = 1'b1;
	logic         slow_rate = 1'b0;
	logic [2:0]   clk_source_sel = 3'h0;
	logic         clk_source_load = 1'b0;
	logic [7:0]   sample_div = 8'h1;
	gsc_int_cfg_t int_cfg = 6'h0;
	gsc_sample_t  adc_sample = 64'h0;
	wire          scl, sda_low, sda;
	logic         sda_out, sda_oe, int_out, int_oe, clk_locked, a;
	logic [2:0]   active_clk_source;
	gsc_status_t  int_status;
	gsc_sample_t  sample_data;
	logic [7:0]   rd [0:9];
	logic [7:0]   d;
	int           errors = 0;
	int           tests_run = 0;
	assign sda = !(sda_low || sda_oe); // pull-up when nobody pulls
	always #25 sys_clk = ~sys_clk;
	always #15 ref_clk = ~ref_clk;
	gsc_core #(.SETTLE_CYC(SETTLE)) u_dut (.sys_clk, .nrst,
		.external_reference_clock_input(ref_clk), .address_select_pin, .scl_in(scl),
		.sda_in(sda), .sda_out, .sda_oe, .int_out, .int_oe, .clk_source_sel, .clk_source_load,
		.slow_rate, .sample_div, .int_cfg, .adc_sample, .active_clk_source, .clk_locked,
		.int_status, .sample_data);
	gsc_i2c_master u_host (.sys_clk, .sda, .scl, .sda_low);
	task automatic check(input logic [63:0] seen, input logic [63:0] exp, input string what);
		tests_run++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %0t %s seen %h exp %h", $time, what, seen, exp);
		end
	endtask : check
	task automatic stop_test;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : stop_test
	task automatic cyc(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : cyc
	// read n bytes from ptr: pointer write, repeated start, burst read
	task automatic rd_burst(input logic [7:0] ptr, input int n);
		u_host.quad(B_START, a);
		u_host.xfer({6'h34, address_select_pin, 1'b0}, 1'b1, d, a);
		check(a, 1'b0, "addr ack");
		u_host.xfer(ptr, 1'b1, d, a);
		check(a, 1'b0, "ptr ack");
		u_host.quad(B_START, a);
		u_host.xfer({6'h34, address_select_pin, 1'b1}, 1'b1, d, a);
		check(a, 1'b0, "read addr ack");
		for (int i = 0; i < n; i++) u_host.xfer(8'hFF, i == n - 1, rd[i], a);
		u_host.quad(B_STOP, a);
	endtask : rd_burst
	// all codes in turn; 6 and 7 must leave the running source alone
	task automatic t_switch;
		logic [2:0] exp_src;
		exp_src = 3'h0;
		for (int i = 1; i <= 8; i++) begin
			clk_source_sel = 3'(i % 8);
			clk_source_load = 1'b1;
			cyc(1);
			clk_source_load = 1'b0;
			cyc(SETTLE + 4);
			if (i < 6 || i == 8) exp_src = 3'(i % 8);
			check(clk_locked, 1'b1, "locked");
			check(active_clk_source, exp_src, "source");
			check(int_status.lock, 1'b1, "lock flag");
		end
	endtask : t_switch
	// own address acks on both pin levels, the neighbour is ignored
	task automatic t_addr;
		for (int p = 0; p < 2; p++) begin
			address_select_pin = p[0];
			cyc(4);
			for (int o = 0; o < 2; o++) begin
				u_host.quad(B_START, a);
				u_host.xfer({6'h34, p[0] ^ o[0], 1'b0}, 1'b1, d, a);
				check(a, o[0], "addr match");
				u_host.quad(B_STOP, a);
			end
		end
	endtask : t_addr
	task automatic wait_sample(output int n);
		n = 0;
		// limit covers one slow-rate period with margin
		while (sample_data !== adc_sample && n < 25000) begin
			cyc(1);
			n++;
		end
		check(sample_data, adc_sample, "sample seen");
	endtask : wait_sample
	// two samples one divided period apart, latched push-pull pin
	task automatic t_sample;
		int n;
		int_cfg = 6'b001001;
		adc_sample = 64'h1234_5678_9ABC_DEF0;
		wait_sample(n);
		adc_sample = 64'h8001_7FFE_0102_FEDC;
		wait_sample(n);
		sample_div = 8'hFF; // park sampling so the reads below stay quiet
		check(n, 5000, "period");
		check(sample_data, adc_sample, "data");
		check(int_status.data, 1'b1, "data flag");
		cyc(2);
		check({int_oe, int_out}, 2'b11, "int high");
		rd_burst(8'h00, 10);
		check(rd[0], {1'b0, 6'h34, address_select_pin}, "addr reg");
		check(rd[1], 8'h05, "status reg");
		for (int i = 0; i < 8; i++) check(rd[2 + i], adc_sample[63 - 8 * i -: 8], "burst");
		cyc(3);
		check(int_status, 2'b00, "cleared");
		check(int_out, 1'b0, "int low");
	endtask : t_sample
	// open drain on lock event, cleared by a status read
	task automatic t_od;
		int_cfg = 6'b011010;
		clk_source_sel = 3'h0;
		clk_source_load = 1'b1;
		cyc(1);
		clk_source_load = 1'b0;
		cyc(SETTLE + 4);
		check({int_oe, int_out}, 2'b10, "od pulls");
		rd_burst(8'h01, 1);
		check(rd[0], 8'h04, "lock status");
		cyc(3);
		check(int_oe, 1'b0, "od released");
	endtask : t_od
	// slow prescale, active-low pulse on the pin, any read clears
	task automatic t_slow;
		int n;
		int_cfg = 6'b100101;
		slow_rate = 1'b1;
		sample_div = 8'h00;
		adc_sample = 64'h0F0F_1E1E_2D2D_3C3C;
		wait_sample(n);
		adc_sample = 64'hC3C3_D2D2_E1E1_F0F0;
		wait_sample(n);
		sample_div = 8'hFF; // park sampling again
		check(n, SLOW_PRESCALE * INT_TICK_CYC, "slow period");
		check(int_out, 1'b1, "pulse idle");
		cyc(1);
		check(int_out, 1'b0, "pulse on");
		cyc(INT_PULSE_CYC - 1);
		check(int_out, 1'b0, "pulse held");
		cyc(1);
		check(int_out, 1'b1, "pulse off");
		check(int_status.data, 1'b1, "data flag kept");
		rd_burst(8'h02, 1);
		check(rd[0], adc_sample[63:56], "temp high");
		cyc(3);
		check(int_status, 2'b00, "any read clears");
	endtask : t_slow
	initial begin
		cyc(10);
		nrst = 1'b1;
		cyc(2);
		check(active_clk_source, 3'h0, "reset source");
		check({clk_locked, int_status}, 3'b100, "reset lock");
		check(sample_data, 64'h0, "reset data");
		check(sda_out, 1'b0, "sda never high");
		t_switch();
		t_addr();
		t_sample();
		t_od();
		t_slow();
		stop_test();
	end
	// two slow periods dominate; roughly 66k cycles expected
	initial begin
		repeat (90000) @(posedge sys_clk);
		errors++;
		stop_test();
	end
endmodule : gsc_core_tb
